// File: tape_seq_defs.svh
`ifndef TAPE_SEQ_DEFS_SVH
`define TAPE_SEQ_DEFS_SVH

// Controller clock and timer rates.
`define CLK_HZ 50000000
`define LONG_RATE_HZ 5000
`define SHORT_RATE_HZ 400000
`define SHORT_DIV (`CLK_HZ / `SHORT_RATE_HZ)

// Register byte offsets on the bus.
`define REG_CTRL 8'h00
`define REG_COMMAND 8'h04
`define REG_STORE_ADDR 8'h08
`define REG_STORE_DATA 8'h0C
`define REG_MASK 8'h10
`define REG_STATUS 8'h14
`define REG_DRIVE 8'h18
`define REG_SEQ 8'h1C

// Field positions in the control register.
`define CTRL_MRESET_BIT 0

// Field positions in the status register.
`define STAT_S1_LSB 0
`define STAT_S2_LSB 8
`define STAT_FB14_BIT 16
`define STAT_FB15_BIT 17
`define STAT_STATE_LSB 20

// Field positions in the drive and sequencer registers.
`define DRV_CMD_LSB 0
`define DRV_WDC_LSB 8
`define DRV_DIV_LSB 16
`define SEQ_LINK_LSB 16

// Reset values.
`define MASK_RESET 8'hFF
`define DIV_RESET 8'h01

// Function codes and mode subcodes handled here.
`define FC_HALT 4'h0
`define FC_SEQUENTIAL_INSTRUCTION 4'h1
`define FC_RETURN 4'h2
`define FC_SHIFT 4'h3
`define MODE_NONE 4'h0
`define MODE_DIVIDER 4'h1
`define MODE_DRIVE 4'h2
`define MODE_LONG 4'h3
`define MODE_SHORT 4'h4
`define MODE_STAT1 4'h5
`define MODE_STAT2 4'h6
`define MODE_WDATA 4'h7
`define MODE_MASKLD 4'h9
`define MODE_LAST_IMM 4'hB
`define MODE_SETCLR 4'hF

`endif

// File: tape_seq_pkg.sv
package tape_seq_pkg;

  // Sequencer states, Gray coded along idle, fetch, execute.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FETCH = 2'b01,
    ST_EXEC = 2'b11
  } seq_state_t;

  // One microinstruction split into its fields.
  typedef struct packed {
    logic [3:0] fcode;
    logic [3:0] mode;
    logic [7:0] field;
  } micro_word_t;

  // Hand-off to the decoders for the subcodes handled elsewhere.
  typedef struct packed {
    logic strobe;
    logic [3:0] mode;
    logic [7:0] field;
  } ext_sub_t;

endpackage

// File: tape_micro_sequencer_decode.sv
`timescale 1ns/100ps
`include "tape_seq_defs.svh"
module tape_micro_sequencer_decode
  import tape_seq_pkg::*;
#(
  parameter int LONG_DIV = `CLK_HZ / `LONG_RATE_HZ,
  parameter int STORE_DEPTH = 1024
)(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Branch logic outside this block.
  input wire logic branch_take_i,
  input wire logic branch_call_i,
  input wire logic [9:0] branch_target_i,
  // Serial write data sources.
  input wire logic write_parity_i,
  input wire logic crc_bit_i,
  input wire logic ms_byte_bit_i,
  input wire logic ls_byte_bit_i,
  // Drive and data-path outputs.
  output logic [7:0] drive_cmd_o,
  output logic [7:0] status1_o,
  output logic [7:0] status2_o,
  output logic write_clock_o,
  output logic write_data_o,
  output logic [7:0] shift_pulse_o,
  output logic long_done_o,
  output logic short_done_o,
  output logic running_o,
  output logic [9:0] micro_address_o,
  // Hand-off to the other subfunction decoders.
  output ext_sub_t ext_sub_o,
  output logic [3:0] set_select_o,
  output logic [2:0] clear_select_o,
  output logic set_clear_strobe_o
);

  seq_state_t state_reg;
  micro_word_t word_reg;
  logic [15:0] store_mem [0:STORE_DEPTH-1];
  logic [9:0] micro_address_counter_reg;
  logic [9:0] link_reg;
  logic [9:0] store_addr_reg;
  logic [7:0] shift_enable_mask_reg;
  logic [7:0] divider_reg;
  logic [7:0] div_cnt_reg;
  logic [1:0] quarter_reg;
  logic [3:0] wdata_ctrl_reg;
  logic write_data_reg;
  logic [6:0] long_cnt_reg;
  logic [6:0] short_cnt_reg;
  logic long_run_reg;
  logic short_run_reg;
  logic [15:0] long_pre_reg;
  logic [7:0] short_pre_reg;
  logic fb15_reg;
  logic fb14_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic wb_req;
  logic wb_wr;
  logic mreset;
  logic start_cmd;
  logic exec;
  logic sub_en;
  logic [3:0] mode_subcode;
  logic div_tick;
  logic long_tick;
  logic short_tick;
  logic [15:0] cmd_val;
  logic [31:0] wr_merged;
  logic [31:0] store_merged;

  // Sets or clears one bit chosen by a 3-bit select.
  function automatic logic [7:0] bit_update(input logic [7:0] old, input logic [2:0] sel,
                                            input logic val);
    logic [7:0] res;
    res = old;
    res[sel] = val;
    return res;
  endfunction

  // Merges write data into an old word under the byte enables.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                        input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old & ~m) | (dat & m);
  endfunction

  // Bus decode; the answer comes one cycle after the request is seen.
  assign wb_req = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wb_wr = wb_req && wb_we_i;
  assign mreset = wb_wr && (wb_adr_i == `REG_CTRL) && wb_sel_i[0]
                  && wb_dat_i[`CTRL_MRESET_BIT];
  // A function result cannot be sliced directly, so the merged words are nets of their own.
  assign wr_merged = merge(32'h0000_0000, wb_dat_i, wb_sel_i);
  assign store_merged = merge({16'h0000, store_mem[store_addr_reg]}, wb_dat_i, wb_sel_i);
  assign cmd_val = wr_merged[15:0];
  assign start_cmd = wb_wr && (wb_adr_i == `REG_COMMAND) && (state_reg == ST_IDLE);
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  // Acknowledge and read data; unmapped addresses answer with zero.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end
    else
    begin
      ack_reg <= wb_req;
      rdata_reg <= 32'h0000_0000;
      if (wb_req && !wb_we_i)
      begin
        case (wb_adr_i)
          `REG_STORE_ADDR: rdata_reg[9:0] <= store_addr_reg;
          `REG_STORE_DATA: rdata_reg[15:0] <= store_mem[store_addr_reg];
          `REG_MASK: rdata_reg[7:0] <= shift_enable_mask_reg;
          `REG_STATUS:
          begin
            rdata_reg[`STAT_S1_LSB +: 8] <= status1_o;
            rdata_reg[`STAT_S2_LSB +: 8] <= status2_o;
            rdata_reg[`STAT_FB14_BIT] <= fb14_reg;
            rdata_reg[`STAT_FB15_BIT] <= fb15_reg;
            rdata_reg[`STAT_STATE_LSB +: 2] <= state_reg;
          end
          `REG_DRIVE:
          begin
            rdata_reg[`DRV_CMD_LSB +: 8] <= drive_cmd_o;
            rdata_reg[`DRV_WDC_LSB +: 4] <= wdata_ctrl_reg;
            rdata_reg[`DRV_DIV_LSB +: 8] <= divider_reg;
          end
          `REG_SEQ:
          begin
            rdata_reg[9:0] <= micro_address_counter_reg;
            rdata_reg[`SEQ_LINK_LSB +: 10] <= link_reg;
          end
          default: rdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Control store loading by software; store words have no reset.
  always_ff @(posedge clk_i)
  begin
    if (wb_wr && (wb_adr_i == `REG_STORE_DATA))
    begin
      store_mem[store_addr_reg] <= store_merged[15:0];
    end
  end

  // Store pointer auto-increments after each data write, easing bulk loads.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      store_addr_reg <= 10'h000;
    else if (wb_wr && (wb_adr_i == `REG_STORE_ADDR))
      store_addr_reg <= wr_merged[9:0];
    else if (wb_wr && (wb_adr_i == `REG_STORE_DATA))
      store_addr_reg <= store_addr_reg + 10'h001;
  end

  // Shift-enable mask, written by software and by subcode 9.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      shift_enable_mask_reg <= `MASK_RESET;
    else if (wb_wr && (wb_adr_i == `REG_MASK))
      shift_enable_mask_reg <= wr_merged[7:0];
    else if (sub_en && (mode_subcode == `MODE_MASKLD))
      shift_enable_mask_reg <= word_reg.field;
  end

  // Field decode of the executing word.
  assign exec = (state_reg == ST_EXEC);
  assign mode_subcode = word_reg.mode;
  assign sub_en = exec && (word_reg.fcode <= `FC_SHIFT)
                  && !(word_reg.fcode == `FC_SHIFT && mode_subcode == `MODE_MASKLD);
  assign running_o = (state_reg != ST_IDLE);
  assign micro_address_o = micro_address_counter_reg;

  // Sequencer state: fetch reads the store, execute acts on the word.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || mreset)
      state_reg <= ST_IDLE;
    else
    begin
      case (state_reg)
        ST_IDLE: if (start_cmd) state_reg <= ST_FETCH;
        ST_FETCH: state_reg <= ST_EXEC;
        ST_EXEC:
          if (word_reg.fcode == `FC_HALT)
            state_reg <= ST_IDLE;
          else
            state_reg <= ST_FETCH;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Instruction register, loaded from the store in the fetch cycle.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      word_reg <= '0;
    else if (state_reg == ST_FETCH)
      word_reg <= micro_word_t'(store_mem[micro_address_counter_reg]);
  end

  // Micro address counter; halt leaves it on the word after the halt.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || mreset)
      micro_address_counter_reg <= 10'h000;
    else if (start_cmd)
      micro_address_counter_reg <= cmd_val[9:0];
    else if (exec)
    begin
      case (word_reg.fcode)
        `FC_RETURN: micro_address_counter_reg <= link_reg;
        `FC_HALT, `FC_SEQUENTIAL_INSTRUCTION, `FC_SHIFT:
          micro_address_counter_reg <= micro_address_counter_reg + 10'h001;
        default:
          if (branch_take_i || branch_call_i)
            micro_address_counter_reg <= branch_target_i;
          else
            micro_address_counter_reg <= micro_address_counter_reg + 10'h001;
      endcase
    end
  end

  // Single link register; a nested call simply overwrites it.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      link_reg <= 10'h000;
    else if (exec && word_reg.fcode > `FC_SHIFT && branch_call_i)
      link_reg <= micro_address_counter_reg + 10'h001;
  end

  // Shift pulses are one cycle long, once per shift-step execution.
  assign shift_pulse_o = (exec && word_reg.fcode == `FC_SHIFT)
                         ? ~shift_enable_mask_reg : 8'h00;

  // Subcodes 8 to 11 go out to the other decoders; 15 feeds set and clear.
  assign ext_sub_o.strobe = sub_en && (mode_subcode > `MODE_WDATA)
                            && (mode_subcode <= `MODE_LAST_IMM);
  assign ext_sub_o.mode = mode_subcode;
  assign ext_sub_o.field = word_reg.field;
  assign set_clear_strobe_o = sub_en && (mode_subcode == `MODE_SETCLR);
  assign set_select_o = word_reg.field[3:0];
  assign clear_select_o = word_reg.field[6:4];

  // Drive command and status bits, each set or cleared by MB4.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || mreset)
    begin
      drive_cmd_o <= 8'h00;
      status1_o <= 8'h00;
      status2_o <= 8'h00;
    end
    else if (sub_en)
    begin
      case (mode_subcode)
        `MODE_DRIVE:
          drive_cmd_o <= bit_update(drive_cmd_o, word_reg.field[2:0], word_reg.field[3]);
        `MODE_STAT1:
          status1_o <= bit_update(status1_o, word_reg.field[2:0], word_reg.field[3]);
        `MODE_STAT2:
          status2_o <= bit_update(status2_o, word_reg.field[2:0], word_reg.field[3]);
        default: drive_cmd_o <= drive_cmd_o;
      endcase
    end
  end

  // Write clock divider: zero stands for 256, so the range is 1 to 256.
  assign div_tick = (div_cnt_reg == divider_reg - 8'h01);
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      divider_reg <= `DIV_RESET;
      div_cnt_reg <= 8'h00;
      quarter_reg <= 2'b00;
    end
    else if (sub_en && mode_subcode == `MODE_DIVIDER)
    begin
      divider_reg <= word_reg.field;
      div_cnt_reg <= 8'h00;
      quarter_reg <= 2'b00;
    end
    else if (div_tick)
    begin
      div_cnt_reg <= 8'h00;
      quarter_reg <= quarter_reg + 2'b01;
    end
    else
      div_cnt_reg <= div_cnt_reg + 8'h01;
  end
  assign write_clock_o = quarter_reg[1];

  // Write data control and the registered serial write bit.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wdata_ctrl_reg <= 4'h0;
      write_data_reg <= 1'b0;
    end
    else
    begin
      if (sub_en && mode_subcode == `MODE_WDATA)
        wdata_ctrl_reg <= word_reg.field[3:0];
      case (wdata_ctrl_reg[2:0])
        3'h0: write_data_reg <= 1'b0;
        3'h1: write_data_reg <= write_parity_i;
        3'h2: write_data_reg <= crc_bit_i;
        3'h3: write_data_reg <= ~crc_bit_i;
        3'h4: write_data_reg <= ms_byte_bit_i;
        3'h5: write_data_reg <= ls_byte_bit_i;
        default: write_data_reg <= 1'b1;
      endcase
    end
  end
  assign write_data_o = write_data_reg;

  // Timer prescalers form the 5 kHz and 400 kHz count ticks.
  assign long_tick = (long_pre_reg == 16'(LONG_DIV - 1));
  assign short_tick = (short_pre_reg == 8'(`SHORT_DIV - 1));
  always_ff @(posedge clk_i)
  begin
    if (rst_i || long_tick || (sub_en && mode_subcode == `MODE_LONG))
      long_pre_reg <= 16'h0000;
    else
      long_pre_reg <= long_pre_reg + 16'h0001;
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i || short_tick || (sub_en && mode_subcode == `MODE_SHORT))
      short_pre_reg <= 8'h00;
    else
      short_pre_reg <= short_pre_reg + 8'h01;
  end

  // Long timer; a reload wins over an overflow in the same cycle.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || mreset)
    begin
      long_run_reg <= 1'b0;
      long_cnt_reg <= 7'h00;
      fb15_reg <= 1'b0;
    end
    else if (sub_en && mode_subcode == `MODE_LONG)
    begin
      long_cnt_reg <= word_reg.field[7:1];
      long_run_reg <= 1'b1;
      fb15_reg <= 1'b0;
    end
    else if (long_run_reg && long_tick)
    begin
      long_cnt_reg <= long_cnt_reg + 7'h01;
      if (long_cnt_reg == 7'h7F)
      begin
        long_run_reg <= 1'b0;
        fb15_reg <= 1'b1;
      end
    end
  end

  // Short timer, same scheme as the long one.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || mreset)
    begin
      short_run_reg <= 1'b0;
      short_cnt_reg <= 7'h00;
      fb14_reg <= 1'b0;
    end
    else if (sub_en && mode_subcode == `MODE_SHORT)
    begin
      short_cnt_reg <= word_reg.field[7:1];
      short_run_reg <= 1'b1;
      fb14_reg <= 1'b0;
    end
    else if (short_run_reg && short_tick)
    begin
      short_cnt_reg <= short_cnt_reg + 7'h01;
      if (short_cnt_reg == 7'h7F)
      begin
        short_run_reg <= 1'b0;
        fb14_reg <= 1'b1;
      end
    end
  end
  assign long_done_o = fb15_reg;
  assign short_done_o = fb14_reg;

  // Checks on the sequencer and the subfunctions.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  halt_to_idle_a: assert property (exec && word_reg.fcode == `FC_HALT
    |=> state_reg == ST_IDLE)
    else $error("halt did not stop the sequencer");
  idle_holds_a: assert property (state_reg == ST_IDLE && !start_cmd
    |=> state_reg == ST_IDLE)
    else $error("sequencer left idle without a command");
  continue_step_a: assert property (exec && word_reg.fcode == `FC_SEQUENTIAL_INSTRUCTION && !mreset
    |=> micro_address_counter_reg == $past(micro_address_counter_reg) + 10'h001)
    else $error("continue did not advance the counter");
  shift_next_a: assert property (exec && word_reg.fcode == `FC_SHIFT && !mreset
    |=> ##1 state_reg == ST_EXEC
    && micro_address_counter_reg == $past(micro_address_counter_reg, 2) + 10'h001)
    else $error("shift step did not move to the next word");
  return_link_a: assert property (exec && word_reg.fcode == `FC_RETURN && !mreset
    |=> micro_address_counter_reg == $past(link_reg))
    else $error("return did not load the link register");
  call_link_a: assert property (exec && word_reg.fcode > `FC_SHIFT && branch_call_i
    |=> link_reg == $past(micro_address_counter_reg) + 10'h001)
    else $error("call did not save the return address");
  shift_pulse_a: assert property (shift_pulse_o != 8'h00
    |-> exec && word_reg.fcode == `FC_SHIFT && shift_pulse_o == ~shift_enable_mask_reg
    ##1 shift_pulse_o == 8'h00)
    else $error("shift pulse wrong or longer than one cycle");
  divider_load_a: assert property (sub_en && mode_subcode == `MODE_DIVIDER
    |=> divider_reg == $past(word_reg.field) && quarter_reg == 2'b00)
    else $error("write clock divider not loaded");
  drive_bit_a: assert property (sub_en && mode_subcode == `MODE_DRIVE && !mreset
    |=> drive_cmd_o[$past(word_reg.field[2:0])] == $past(word_reg.field[3]))
    else $error("drive command bit not updated");
  long_done_a: assert property (long_run_reg && long_tick && long_cnt_reg == 7'h7F
    && !sub_en && !mreset |=> fb15_reg && !long_run_reg)
    else $error("long timer overflow not flagged");
  reset_abort_a: assert property (mreset
    |=> micro_address_counter_reg == 10'h000 && state_reg == ST_IDLE && !long_run_reg)
    else $error("master reset did not abort");

endmodule

// File: tape_far_side.sv
`timescale 1ns/100ps
module tape_far_side (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Address seen by the branch logic.
  input wire logic [9:0] micro_address_i,
  // Serial write sources.
  output logic write_parity_o,
  output logic crc_bit_o,
  output logic ms_byte_bit_o,
  output logic ls_byte_bit_o,
  // Branch requests.
  output logic branch_take_o,
  output logic branch_call_o,
  output logic [9:0] branch_target_o
);
  logic [3:0] pattern_reg;

  // The source pattern steps by 3 every cycle, so a stale or wrong selection shows up within a few cycles.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pattern_reg <= 4'h0;
    else
      pattern_reg <= pattern_reg + 4'h3;
  end

  // Every jump or call word lands eight words further on, so a second call can sit at the first call's target.
  assign write_parity_o = pattern_reg[0];
  assign crc_bit_o = pattern_reg[1];
  assign ms_byte_bit_o = pattern_reg[2];
  assign ls_byte_bit_o = pattern_reg[3];
  assign branch_take_o = 1'b1;
  assign branch_call_o = 1'b1;
  assign branch_target_o = micro_address_i + 10'h008;
endmodule

// File: testbench.sv
`timescale 1ns/100ps
`include "tape_seq_defs.svh"
module testbench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'hF;
  logic [31:0] wb_dat = 32'h0;
  logic [31:0] wb_rdat;
  logic wb_ack, take, call, par, crc, ms, ls, wclk, wdat, ldone, sdone, running;
  logic [9:0] target, maddr;
  logic [7:0] shift_pulse, pulse_val;
  logic [31:0] q;
  int num_errors = 0;
  int n_checks = 0;
  int pulse_cnt = 0;
  int rises;
  int ext_cnt = 0;
  int sc_cnt = 0;
  logic wprev;
  logic [12:0] ext_sub, ext_last;
  logic [3:0] set_sel;
  logic [2:0] clr_sel;
  logic sc_strobe;
  logic [6:0] sc_last;

  // Free-running controller clock.
  always #10 clk_i = ~clk_i;

  tape_micro_sequencer_decode #(.LONG_DIV(10)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .branch_take_i(take),
    .branch_call_i(call), .branch_target_i(target), .write_parity_i(par),
    .crc_bit_i(crc), .ms_byte_bit_i(ms), .ls_byte_bit_i(ls), .drive_cmd_o(),
    .status1_o(), .status2_o(), .write_clock_o(wclk), .write_data_o(wdat),
    .shift_pulse_o(shift_pulse), .long_done_o(ldone), .short_done_o(sdone),
    .running_o(running), .micro_address_o(maddr), .ext_sub_o(ext_sub),
    .set_select_o(set_sel), .clear_select_o(clr_sel), .set_clear_strobe_o(sc_strobe));

  tape_far_side u_far (
    .clk_i(clk_i), .rst_i(rst_i), .micro_address_i(maddr),
    .write_parity_o(par), .crc_bit_o(crc), .ms_byte_bit_o(ms),
    .ls_byte_bit_o(ls), .branch_take_o(take), .branch_call_o(call),
    .branch_target_o(target));

  // Count shift pulses as the edge that ends each execute cycle samples them.
  always @(posedge clk_i)
  begin
    if (shift_pulse !== 8'h00)
    begin
      pulse_cnt++;
      pulse_val = shift_pulse;
    end
    if (ext_sub[12] === 1'b1)
    begin
      ext_cnt++;
      ext_last = ext_sub;
    end
    if (sc_strobe === 1'b1)
    begin
      sc_cnt++;
      sc_last = {clr_sel, set_sel};
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_checks++;
    if (g !== x)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, x, g);
    end
  endtask

  // One classic cycle; the request stands until ack is sampled high.
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack !== 1'b1 && n < 20);
    q = wb_rdat;
    if (n >= 20)
      num_errors++;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  task automatic load(input logic [9:0] a, input logic [15:0] w[$]);
    bus(`REG_STORE_ADDR, 1'b1, {22'h0, a});
    foreach (w[i])
      bus(`REG_STORE_DATA, 1'b1, {16'h0, w[i]});
  endtask

  // Start at an address and wait, bounded, until the sequencer halts.
  task automatic run(input logic [9:0] a);
    int n;
    n = 0;
    bus(`REG_COMMAND, 1'b1, {22'h0, a});
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (running !== 1'b0 && n < 2000);
    if (n >= 2000)
      num_errors++;
  endtask

  // The chosen source reaches the output register one cycle later.
  task automatic wsrc(input int s);
    logic p;
    repeat (3)
    begin
      @(negedge clk_i);
      case (s)
        0: p = 1'b0;
        1: p = par;
        2: p = crc;
        3: p = ~crc;
        4: p = ms;
        5: p = ls;
        default: p = 1'b1;
      endcase
      @(negedge clk_i);
      chk("write data", {31'h0, p}, {31'h0, wdat});
    end
  endtask

  // Hang guard, far beyond the well under a thousand cycles the tests need.
  initial
  begin
    repeat (30000) @(posedge clk_i);
    num_errors++;
    give_verdict();
  end

  // Main sequence.
  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    load(10'h000, '{16'h120B, 16'h150E, 16'h160D, 16'h1105, 16'h1704,
                    16'h19F0, 16'h3000, 16'h3900, 16'h020F});
    run(10'h000);
    bus(`REG_SEQ, 1'b0, 32'h0);
    chk("counter", 32'h9, q & 32'h3FF);
    bus(`REG_DRIVE, 1'b0, 32'h0);
    chk("drive", 32'h0005_0488, q);
    bus(`REG_STATUS, 1'b0, 32'h0);
    chk("status", 32'h0000_2040, q);
    bus(`REG_MASK, 1'b0, 32'h0);
    chk("mask", 32'hF0, q);
    chk("pulse count", 32'd2, pulse_cnt);
    chk("pulse value", 32'h0F, {24'h0, pulse_val});
    rises = 0;
    @(negedge clk_i);
    wprev = wclk;
    repeat (80)
    begin
      @(negedge clk_i);
      if (wclk === 1'b1 && wprev === 1'b0)
        rises++;
      wprev = wclk;
    end
    chk("clock rises", 32'd4, rises);
    chk("idle", 32'h0, {31'h0, running});
    $display("test program one done");
    for (int s = 0; s < 8; s++)
    begin
      load(10'h010, '{16'h1700 | s[15:0], 16'h0000});
      run(10'h010);
      wsrc(s);
    end
    $display("test write sources done");
    load(10'h018, '{16'h13FC, 16'h14FC, 16'h0000});
    run(10'h018);
    chk("long early", 32'h0, {31'h0, ldone});
    repeat (30) @(posedge clk_i);
    chk("long done", 32'h1, {31'h0, ldone});
    chk("short early", 32'h0, {31'h0, sdone});
    repeat (260) @(posedge clk_i);
    bus(`REG_STATUS, 1'b0, 32'h0);
    chk("timers", 32'h0003_2040, q);
    $display("test timers done");
    load(10'h020, '{16'h7000, 16'h0000});
    load(10'h028, '{16'h7000, 16'h0000});
    load(10'h030, '{16'h2000});
    run(10'h020);
    bus(`REG_SEQ, 1'b0, 32'h0);
    chk("link", 32'h0029_002A, q & 32'h03FF_03FF);
    $display("test subroutine done");
    load(10'h038, '{16'h1F5A, 16'h3A33, 16'h0B11});
    run(10'h038);
    chk("ext strobes", 32'd3, ext_cnt);
    chk("ext word", 32'h1B11, {19'h0, ext_last});
    chk("set clear strobes", 32'd1, sc_cnt);
    chk("set clear selects", 32'h5A, {25'h0, sc_last});
    $display("test hand-off done");
    bus(`REG_CTRL, 1'b1, 32'h1);
    bus(`REG_SEQ, 1'b0, 32'h0);
    chk("reset counter", 32'h0, q & 32'h3FF);
    bus(`REG_DRIVE, 1'b0, 32'h0);
    chk("reset drive", 32'h0, q & 32'hFF);
    bus(`REG_STATUS, 1'b0, 32'h0);
    chk("reset status", 32'h0, q);
    bus(8'h40, 1'b0, 32'h0);
    chk("unmapped", 32'h0, q);
    $display("test master reset done");
    give_verdict();
  end
endmodule
